/* src/pressure_window_cal_status_regs.sv */
// Window comparator, offset calibration and signal-path status registers
//
// Contract
// - Threshold and offset writes take effect only while the lock bit is clear.
// - Threshold and offset bytes are covered by parity error detection.
// - Each pressure sample arriving outside a data-path restart is compared with high and low window thresholds.
// - Thresholds are unsigned 16-bit, high at 46h/47h, low at 48h/49h.
// - A zero threshold disables only its own comparison.
// - Both thresholds zero keeps the interrupt output inactive.
// - Signed 16-bit offset at 4Ch/4Dh is added to the pressure output.
// - Changing the offset restarts the pressure data path.
// - Self-test pending flag set by reset, cleared once a self-test selected.
// - Self-test running flag is the OR of the four select bits.
// - Common-mode fault flag set when the front end leaves its limits.
// - Common-mode flag cleared by status read or by a reporting transmission.
// - Self-test failure flag is set on failure and cleared only by reset.
// - Read-only status mirror at 61h; reading it has the original's effects.
// - Mirror layout: 7 path, 6 reserved, 5 link, 4 mem, 3 supply, 2..0.
// - Polarity one fires outside the window, zero fires inside it.
// - Interrupt follows the latest evaluated sample, cleared while both thresholds are zero.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module pressure_window_cal_status_regs
   import pwcs_pkg::*;
#(
   parameter logic [REINIT_W-1:0] REINIT_CYCLES =
      REINIT_W'(REINIT_CYCLES_DEF)
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic raw_valid,
   input wire logic [15:0] raw_pressure,
   input wire logic cm_exceed,
   input wire logic tx_cm_reported,
   input wire logic selftest_failed,
   input wire logic [7:0] device_status,
   output logic [15:0] sensor_output,
   output logic sensor_valid,
   output logic irq,
   output logic dsp_restart,
   output logic dsp_busy,
   output logic array_error,
   output logic device_status_read
);

   // Bus request capture
   logic take;
   logic [7:0] req_idx;
   logic wr_pend_reg;
   logic [7:0] wr_idx_reg;
   logic rd_wait_reg;
   logic [7:0] rd_idx_reg;
   logic hreadyout_reg;
   logic [31:0] hrdata_reg;
   logic hresp_reg;
   logic wr_en;
   logic [7:0] wdata;

   assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign req_idx = haddr[9:2];
   assign wr_en = wr_pend_reg;
   assign wdata = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= 8'h00;
         rd_wait_reg <= 1'b0;
         rd_idx_reg <= 8'h00;
      end else begin
         wr_pend_reg <= take && hwrite;
         wr_idx_reg <= take ? req_idx : wr_idx_reg;
         rd_wait_reg <= take && !hwrite;
         rd_idx_reg <= take ? req_idx : rd_idx_reg;
      end
   end

   // Reads take one wait state, so a write just before is already stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         hreadyout_reg <= !(take && !hwrite);
         hresp_reg <= 1'b0;
      end
   end

   // Lock and control registers
   logic lock_reg;
   logic [3:0] select_reg;
   logic pol_reg;
   logic wr_lock;
   logic wr_ctrl;

   assign wr_lock = wr_en && (wr_idx_reg == IDX_LOCK);
   assign wr_ctrl = wr_en && (wr_idx_reg == IDX_CTRL);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_reg <= 1'b0;
      end else if (wr_lock && wdata[LOCK_BIT]) begin
         lock_reg <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         select_reg <= SELECT_RESET;
         pol_reg <= POL_RESET;
      end else if (wr_ctrl) begin
         select_reg <= wdata[3:0];
         pol_reg <= wdata[CTRL_POL_BIT];
      end
   end

   // Calibration bytes: thresholds and offset
   logic [7:0] cal_reg [CAL_BYTES];
   logic [7:0] cal_next [CAL_BYTES];
   logic [CAL_BYTES-1:0] cal_wr;
   logic [CAL_BYTES-1:0] next_par;
   logic [CAL_BYTES-1:0] cur_par;

   for (genvar i = 0; i < CAL_BYTES; i++) begin : g_cal
      assign cal_wr[i] = wr_en && (wr_idx_reg == CAL_IDX[i]) &&
         !lock_reg;
      assign cal_next[i] = cal_wr[i] ? wdata : cal_reg[i];
      assign next_par[i] = ^cal_next[i];
      assign cur_par[i] = ^cal_reg[i];
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cal_reg[i] <= CAL_RESET;
         end else begin
            cal_reg[i] <= cal_next[i];
         end
      end
   end

   logic [15:0] hi_thr;
   logic [15:0] lo_thr;
   logic [15:0] user_offset;

   assign hi_thr = {cal_reg[1], cal_reg[0]};
   assign lo_thr = {cal_reg[3], cal_reg[2]};
   assign user_offset = {cal_reg[POS_OFF_H], cal_reg[POS_OFF_L]};

   // Parity kept over the whole array, checked every cycle
   logic parity_reg;
   logic array_error_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         parity_reg <= 1'b0;
         array_error_reg <= 1'b0;
      end else begin
         parity_reg <= ^next_par;
         array_error_reg <= (^cur_par) != parity_reg;
      end
   end

   // Offset change restarts the data path
   logic off_change;
   logic [REINIT_W-1:0] reinit_cnt_reg;
   logic [REINIT_W-1:0] reinit_next;
   logic dsp_restart_reg;
   logic dsp_busy_reg;

   assign off_change =
      (cal_wr[POS_OFF_L] && (wdata != cal_reg[POS_OFF_L])) ||
      (cal_wr[POS_OFF_H] && (wdata != cal_reg[POS_OFF_H]));
   assign reinit_next = off_change ? REINIT_CYCLES :
      (reinit_cnt_reg != '0) ? reinit_cnt_reg - 1'b1 : reinit_cnt_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reinit_cnt_reg <= '0;
         dsp_restart_reg <= 1'b0;
         dsp_busy_reg <= 1'b0;
      end else begin
         reinit_cnt_reg <= reinit_next;
         dsp_restart_reg <= off_change;
         dsp_busy_reg <= reinit_next != '0;
      end
   end

   // Offset applied to the raw sample, then window evaluation
   logic eval;
   logic [15:0] corrected;
   logic above_hi;
   logic below_lo;
   logic outside;
   logic both_off;
   logic irq_cond;
   logic irq_next;
   logic [15:0] sensor_out_reg;
   logic sensor_valid_reg;
   logic irq_reg;

   assign eval = raw_valid && (reinit_cnt_reg == '0) &&
      !off_change;
   assign corrected = raw_pressure + user_offset;
   assign above_hi = (hi_thr != 16'h0000) && (corrected > hi_thr);
   assign below_lo = (lo_thr != 16'h0000) && (corrected < lo_thr);
   assign outside = above_hi || below_lo;
   assign both_off = (hi_thr == 16'h0000) && (lo_thr == 16'h0000);
   assign irq_cond = !both_off && (pol_reg ? outside : !outside);
   assign irq_next = eval ? irq_cond : (irq_reg && !both_off);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sensor_out_reg <= 16'h0000;
         sensor_valid_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         sensor_out_reg <= eval ? corrected : sensor_out_reg;
         sensor_valid_reg <= eval;
         irq_reg <= irq_next;
      end
   end

   // Signal-path status
   logic stat_read;
   logic mirror_read;
   logic cm_clear;
   logic pending_reg;
   logic cm_reg;
   logic fail_reg;
   logic device_status_read_reg;
   sp_status_type sp_status;
   logic [7:0] mirror_val;

   assign stat_read = rd_wait_reg && (rd_idx_reg == IDX_STAT);
   assign mirror_read = rd_wait_reg && (rd_idx_reg == IDX_MIRROR);
   assign cm_clear = stat_read || tx_cm_reported;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending_reg <= PENDING_RESET;
         cm_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         pending_reg <= pending_reg && (select_reg == 4'h0);
         cm_reg <= cm_exceed || (cm_reg && !cm_clear);
         fail_reg <= fail_reg || selftest_failed;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         device_status_read_reg <= 1'b0;
      end else begin
         device_status_read_reg <= mirror_read;
      end
   end

   assign sp_status.reserved = 4'h0;
   assign sp_status.pending = pending_reg;
   assign sp_status.running = |select_reg;
   assign sp_status.cm_fault = cm_reg;
   assign sp_status.fail = fail_reg;
   assign mirror_val = device_status &
      ~(8'h01 << MIRROR_RSVD_BIT);

   // Read data selection
   logic [7:0] rd_val;

   always_comb begin
      if (rd_idx_reg == IDX_LOCK) begin
         rd_val = {7'h00, lock_reg};
      end else if (rd_idx_reg == IDX_HI_L) begin
         rd_val = hi_thr[7:0];
      end else if (rd_idx_reg == IDX_HI_H) begin
         rd_val = hi_thr[15:8];
      end else if (rd_idx_reg == IDX_LO_L) begin
         rd_val = lo_thr[7:0];
      end else if (rd_idx_reg == IDX_LO_H) begin
         rd_val = lo_thr[15:8];
      end else if (rd_idx_reg == IDX_OFF_L) begin
         rd_val = user_offset[7:0];
      end else if (rd_idx_reg == IDX_OFF_H) begin
         rd_val = user_offset[15:8];
      end else if (rd_idx_reg == IDX_CTRL) begin
         rd_val = {3'h0, pol_reg, select_reg};
      end else if (rd_idx_reg == IDX_STAT) begin
         rd_val = sp_status;
      end else if (rd_idx_reg == IDX_MIRROR) begin
         rd_val = mirror_val;
      end else begin
         rd_val = 8'h00;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_wait_reg) begin
         hrdata_reg <= {24'h00_0000, rd_val};
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign sensor_output = sensor_out_reg;
   assign sensor_valid = sensor_valid_reg;
   assign irq = irq_reg;
   assign dsp_restart = dsp_restart_reg;
   assign dsp_busy = dsp_busy_reg;
   assign array_error = array_error_reg;
   assign device_status_read = device_status_read_reg;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence mirror_req_s;
      take && !hwrite && (req_idx == IDX_MIRROR);
   endsequence

   sequence mirror_done_s;
      !hreadyout_reg ##1 hreadyout_reg && device_status_read_reg;
   endsequence

   sequence stat_req_s;
      take && !hwrite && (req_idx == IDX_STAT);
   endsequence

   locked_cal_hold_a: assert property (
      lock_reg && wr_en && (wr_idx_reg == IDX_OFF_L) |=>
         $stable(user_offset[7:0]))
      else $error("calibration byte changed while locked");

   parity_clean_a: assert property (
      wr_en ##1 !wr_en |=> !array_error_reg)
      else $error("parity error after a clean write");

   irq_outside_a: assert property (
      eval && pol_reg && above_hi |=> irq_reg)
      else $error("interrupt missing above high threshold");

   irq_lowonly_a: assert property (
      eval && pol_reg && (hi_thr == 16'h0000) && (lo_thr != 16'h0000) &&
         (corrected < lo_thr) |=> irq_reg)
      else $error("low threshold not working alone");

   irq_disabled_a: assert property (
      both_off ##1 both_off |-> !irq_reg)
      else $error("interrupt active with both thresholds zero");

   irq_follow_a: assert property (
      eval && !pol_reg && outside |=> !irq_reg ##1 ($past(eval) || !irq_reg))
      else $error("interrupt active for a sample outside the window");

   offset_sum_a: assert property (
      eval |=> sensor_valid_reg &&
         (sensor_out_reg == 16'($past(raw_pressure) + $past(user_offset))))
      else $error("output differs from sample plus offset");

   restart_path_a: assert property (
      off_change |=> dsp_restart_reg && dsp_busy_reg && !sensor_valid_reg)
      else $error("offset change did not restart the path");

   pending_clear_a: assert property (
      (select_reg != 4'h0) |=> !pending_reg ##1 !pending_reg)
      else $error("self-test pending flag not cleared");

   running_read_a: assert property (
      stat_req_s ##1 ($stable(select_reg)) |=> hrdata_reg[2] == |select_reg)
      else $error("running flag differs from select bits");

   cm_set_a: assert property (
      cm_exceed |=> cm_reg)
      else $error("common-mode event lost");

   cm_clear_a: assert property (
      stat_req_s ##1 !cm_exceed |=> !cm_reg)
      else $error("common-mode flag not cleared by status read");

   fail_sticky_a: assert property (
      fail_reg |=> fail_reg)
      else $error("self-test failure flag cleared without reset");

   mirror_read_a: assert property (
      mirror_req_s |=> mirror_done_s)
      else $error("mirror read side effect missing");

   mirror_rsvd_a: assert property (
      mirror_read |=> !hrdata_reg[MIRROR_RSVD_BIT])
      else $error("reserved mirror bit reads one");

   irq_polarity_a: assert property (
      eval && !pol_reg && !outside && !both_off |=> irq_reg)
      else $error("interrupt missing inside the window");

   unsigned_cmp_a: assert property (
      eval && pol_reg && (hi_thr == 16'h7fff) && corrected[15] |=> irq_reg)
      else $error("high comparison is not unsigned");

endmodule : pressure_window_cal_status_regs

/* src/pwcs_pkg.sv */
// Constants and types shared by the pressure window and calibration registers
package pwcs_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_LOCK = 8'h10;
   localparam logic [7:0] IDX_HI_L = 8'h46;
   localparam logic [7:0] IDX_HI_H = 8'h47;
   localparam logic [7:0] IDX_LO_L = 8'h48;
   localparam logic [7:0] IDX_LO_H = 8'h49;
   localparam logic [7:0] IDX_OFF_L = 8'h4c;
   localparam logic [7:0] IDX_OFF_H = 8'h4d;
   localparam logic [7:0] IDX_CTRL = 8'h50;
   localparam logic [7:0] IDX_STAT = 8'h60;
   localparam logic [7:0] IDX_MIRROR = 8'h61;
   // Calibration byte array, in storage order
   localparam int CAL_BYTES = 6;
   localparam logic [7:0] CAL_IDX [CAL_BYTES] = '{
      IDX_HI_L, IDX_HI_H, IDX_LO_L, IDX_LO_H, IDX_OFF_L, IDX_OFF_H};
   localparam int POS_OFF_L = 4;
   localparam int POS_OFF_H = 5;
   // Field positions
   localparam int LOCK_BIT = 0;
   localparam int CTRL_POL_BIT = 4;
   localparam int MIRROR_RSVD_BIT = 6;
   // Values after reset
   localparam logic [7:0] CAL_RESET = 8'h00;
   localparam logic [3:0] SELECT_RESET = 4'h0;
   localparam logic POL_RESET = 1'b0;
   localparam logic PENDING_RESET = 1'b1;
   // AHB transfer type with a request
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int REINIT_TIME_US = 1000;
   localparam int REINIT_CYCLES_DEF = REINIT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int REINIT_W = 16;

   typedef struct packed {
      logic [3:0] reserved;
      logic pending;
      logic running;
      logic cm_fault;
      logic fail;
   } sp_status_type;
endpackage : pwcs_pkg

/* tb/pwcs_host.sv */
// Bus master model standing in for the host controller
`timescale 1ns/1ns
module pwcs_host
   import pwcs_pkg::*;
(
   input wire logic hclk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic timed_out
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      timed_out = 1'b0;
   end

   // Holds the current phase until hready is seen high at an edge
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) timed_out <= 1'b1;
   endtask : wait_ready

   // One single word transfer; released lines show the inverse value
   task automatic access(input logic wr, input logic [7:0] idx,
                         input logic [7:0] wd, output logic [7:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      haddr <= ~haddr;
      hwdata <= {24'h0, wd};
      wait_ready();
      rd = hrdata[7:0];
      hwdata <= ~hwdata;
   endtask : access
endmodule : pwcs_host

/* tb/pressure_window_cal_status_regs_test.sv */
// Self-checking bench for the window, offset and status registers
`timescale 1ns/1ns
module pressure_window_cal_status_regs_test;
   import pwcs_pkg::*;
   localparam logic [15:0] REINIT = 16'h0008;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, timed_out;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic raw_valid = 1'b0;
   logic [15:0] raw_pressure = 16'h0;
   logic cm_exceed = 1'b0;
   logic tx_cm_reported = 1'b0;
   logic selftest_failed = 1'b0;
   logic [7:0] device_status = 8'hff;
   logic [15:0] sensor_output;
   logic sensor_valid, irq, dsp_restart, dsp_busy, array_error;
   logic device_status_read;
   int n_errors = 0;
   int checks_done = 0;
   int n_restart = 0;
   int n_mirror = 0;
   int base;
   logic [7:0] rdv;

   always #20 hclk = ~hclk;

   pwcs_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .timed_out(timed_out));

   pressure_window_cal_status_regs #(.REINIT_CYCLES(REINIT)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .raw_valid(raw_valid), .raw_pressure(raw_pressure),
      .cm_exceed(cm_exceed), .tx_cm_reported(tx_cm_reported),
      .selftest_failed(selftest_failed), .device_status(device_status),
      .sensor_output(sensor_output), .sensor_valid(sensor_valid),
      .irq(irq), .dsp_restart(dsp_restart), .dsp_busy(dsp_busy),
      .array_error(array_error), .device_status_read(device_status_read));

   always @(posedge hclk) begin
      if (dsp_restart === 1'b1) n_restart++;
      if (device_status_read === 1'b1) n_mirror++;
   end

   always @(posedge timed_out) begin
      n_errors++;
      conclude();
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      host.access(1'b1, idx, d, rdv);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      host.access(1'b0, idx, 8'h00, rdv);
      check({8'h0, rdv}, {8'h0, exp});
   endtask : rd_chk

   task automatic smp(input logic [15:0] p, input logic [15:0] o,
                      input logic q);
      @(posedge hclk);
      raw_valid <= 1'b1;
      raw_pressure <= p;
      @(posedge hclk);
      raw_valid <= 1'b0;
      raw_pressure <= ~p;
      #1;
      check(16'(sensor_valid), 16'h0001);
      check(sensor_output, o);
      check(16'(irq), 16'(q));
   endtask : smp

   // Pulses {cm_exceed, tx_cm_reported, selftest_failed} for one cycle
   task automatic ev(input logic [2:0] m);
      @(posedge hclk);
      {cm_exceed, tx_cm_reported, selftest_failed} <= m;
      @(posedge hclk);
      {cm_exceed, tx_cm_reported, selftest_failed} <= 3'b000;
   endtask : ev

   task automatic wait_busy();
      int n;
      n = 0;
      while (dsp_busy !== 1'b0 && n < 100) begin
         @(posedge hclk);
         n++;
      end
      if (dsp_busy !== 1'b0) begin
         n_errors++;
         conclude();
      end
   endtask : wait_busy

   task automatic t_reset();
      rd_chk(IDX_STAT, 8'h08);
      for (int i = 0; i < CAL_BYTES; i++) rd_chk(CAL_IDX[i], 8'h00);
      rd_chk(IDX_MIRROR, 8'hbf);
      device_status <= 8'h6d;
      wr(IDX_MIRROR, 8'h00);
      rd_chk(IDX_MIRROR, 8'h2d);
      rd_chk(8'h7f, 8'h00);
      check(16'(n_mirror), 16'h0002);
      $display("test reset done");
   endtask : t_reset

   task automatic t_window();
      wr(IDX_HI_L, 8'hff);
      wr(IDX_HI_H, 8'h7f);
      wr(IDX_CTRL, 8'h10);
      smp(16'h8000, 16'h8000, 1'b1);
      wr(IDX_HI_L, 8'h00);
      wr(IDX_HI_H, 8'h10);
      wr(IDX_LO_H, 8'h08);
      rd_chk(IDX_HI_H, 8'h10);
      rd_chk(IDX_LO_H, 8'h08);
      wr(IDX_CTRL, 8'h10);
      smp(16'h1001, 16'h1001, 1'b1);
      smp(16'h1000, 16'h1000, 1'b0);
      smp(16'h0800, 16'h0800, 1'b0);
      smp(16'h07ff, 16'h07ff, 1'b1);
      wr(IDX_CTRL, 8'h00);
      smp(16'h0900, 16'h0900, 1'b1);
      smp(16'h1001, 16'h1001, 1'b0);
      wr(IDX_HI_H, 8'h00);
      smp(16'hffff, 16'hffff, 1'b1);
      smp(16'h07ff, 16'h07ff, 1'b0);
      wr(IDX_CTRL, 8'h10);
      smp(16'h07ff, 16'h07ff, 1'b1);
      smp(16'hffff, 16'hffff, 1'b0);
      wr(IDX_LO_H, 8'h00);
      smp(16'h0900, 16'h0900, 1'b0);
      wr(IDX_CTRL, 8'h00);
      smp(16'h0900, 16'h0900, 1'b0);
      $display("test window done");
   endtask : t_window

   task automatic t_offset();
      base = n_restart;
      wr(IDX_OFF_L, 8'hff); // low byte of a trim of minus one; a zero sample wraps to ffffh
      @(posedge hclk);
      #1;
      check(16'(dsp_busy), 16'h0001);
      @(posedge hclk);
      raw_valid <= 1'b1;
      raw_pressure <= 16'h0100;
      @(posedge hclk);
      raw_valid <= 1'b0;
      #1;
      check(16'(sensor_valid), 16'h0000);
      wr(IDX_OFF_H, 8'hff);
      wait_busy(); // no samples until the path is back
      check(16'(n_restart - base), 16'h0002);
      rd_chk(IDX_OFF_H, 8'hff);
      smp(16'h0100, 16'h00ff, 1'b0);
      smp(16'h0000, 16'hffff, 1'b0);
      $display("test offset done");
   endtask : t_offset

   task automatic t_status();
      ev(3'b100);
      rd_chk(IDX_STAT, 8'h0a);
      rd_chk(IDX_STAT, 8'h08);
      ev(3'b100);
      ev(3'b010);
      rd_chk(IDX_STAT, 8'h08);
      ev(3'b001);
      rd_chk(IDX_STAT, 8'h09);
      rd_chk(IDX_STAT, 8'h09);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_CTRL, 8'(1 << i));
         rd_chk(IDX_STAT, 8'h05);
      end
      wr(IDX_CTRL, 8'h00);
      rd_chk(IDX_STAT, 8'h01);
      $display("test status done");
   endtask : t_status

   task automatic t_lock();
      wr(IDX_LOCK, 8'h01);
      base = n_restart;
      wr(IDX_HI_L, 8'h55);
      rd_chk(IDX_HI_L, 8'h00);
      wr(IDX_OFF_L, 8'h00);
      rd_chk(IDX_OFF_L, 8'hff);
      check(16'(n_restart - base), 16'h0000);
      check(16'(array_error), 16'h0000);
      check(16'(hresp), 16'h0000);
      $display("test lock done");
   endtask : t_lock

   // Reset in mid-run: flags return to their reset state, lock is lifted
   task automatic t_rereset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(IDX_STAT, 8'h08);
      rd_chk(IDX_LOCK, 8'h00);
      wr(IDX_HI_L, 8'h55);
      rd_chk(IDX_HI_L, 8'h55);
      $display("test second reset done");
   endtask : t_rereset

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_window();
      t_offset();
      t_status();
      t_lock();
      t_rereset();
      conclude();
   end
endmodule : pressure_window_cal_status_regs_test
